// [verilog/ivd_regs.svh]
`ifndef IVD_REGS_SVH
`define IVD_REGS_SVH
// Register offsets on the plain register port
`define IVD_OFS_FLAGS 12'h000
`define IVD_OFS_BASE 12'h001
`define IVD_OFS_MATCH 12'h002
`define IVD_OFS_MATCH_EN 12'h003
`define IVD_OFS_MODE 12'h004
`define IVD_OFS_EDGE 12'h005
`define IVD_OFS_ICR 12'h040
`define IVD_ICR_MASK 12'hFE0
`define IVD_OFS_CAUSE 12'h35F
// Field positions
`define IVD_CAUSE_SEL8_BIT 6
`define IVD_CAUSE_SEL9_BIT 7
`define IVD_ICR_REQ_BIT 3
`define IVD_MODE_TWOWIRE_BIT 0
// Pin indices in the synchronised pin vector
`define IVD_PIN_RST 0
`define IVD_PIN_NMI 1
`define IVD_PIN_KEY 2
`define IVD_PIN_EXT 3
`define IVD_PIN_RST_VAL 9'h007
// Fixed vector addresses
`define IVD_VEC_UND 20'hFFFDC
`define IVD_VEC_OVF 20'hFFFE0
`define IVD_VEC_BRK 20'hFFFE4
`define IVD_VEC_MATCH 20'hFFFE8
`define IVD_VEC_STEP 20'hFFFEC
`define IVD_VEC_WDT 20'hFFFF0
`define IVD_VEC_DBC 20'hFFFF4
`define IVD_VEC_NMI 20'hFFFF8
`define IVD_VEC_RST 20'hFFFFC
// Dispatch constants
`define IVD_BRK_REDIRECT 8'hFF
`define IVD_IPL_TOP 3'h7
`define IVD_IPL_RESET 3'h0
`define IVD_TRAP_SPLIT 6'h20
`define IVD_FETCH_BYTES 2'h3
`define IVD_FLAGS_RST 6'h00
`endif

// [verilog/ivd_pkg.sv]
`default_nettype none
package ivd_pkg;
	typedef enum logic [2:0] {
		IVD_IDLE = 3'b001,
		IVD_FETCH = 3'b010,
		IVD_DONE = 3'b100
	} ivd_fsm_type;
	typedef enum logic [3:0] {
		K_NONE, K_RST, K_NMI, K_DBC, K_WDT, K_UND, K_OVF, K_BRK, K_TRAP, K_STEP, K_MATCH, K_MASK
	} ivd_kind_type;
	typedef struct packed {
		logic req;
		logic [2:0] lvl;
	} ivd_ctl_type;
	typedef struct packed {
		logic [2:0] processor_priority_level;
		logic u;
		logic d;
		logic i;
	} ivd_flag_type;
	typedef struct packed {
		logic bound;
		logic [19:0] next_addr;
		logic break_instr;
		logic undefined_opcode_instr;
		logic ovf;
		logic trap;
		logic [5:0] trap_num;
		logic reti;
		logic dbc;
		logic wdt;
	} ivd_cpu_ev_type;
	typedef struct packed {
		logic we;
		logic re;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ivd_bus_req_type;
	typedef struct packed {
		logic prev;
		logic hit;
	} ivd_edge_type;
	typedef struct packed {
		ivd_fsm_type fsm;
		ivd_ctl_type [31:0] ctl;
		ivd_flag_type flags;
		ivd_flag_type saved;
		logic [19:0] base;
		logic [19:0] match_addr;
		logic match_en;
		logic twowire;
		logic [1:0] cause_sel;
		logic [11:0] edge_cfg;
		logic rst_pend;
		logic nmi_pend;
		logic dbc_pend;
		logic wdt_pend;
		logic nmi_prev;
		logic brk_redo;
		logic [19:0] vec;
		logic [19:0] pc;
		logic [1:0] iss;
		logic [1:0] got;
		logic mem_rd;
		logic [19:0] mem_addr;
		logic pc_valid;
		logic cpu_reset;
		logic busy;
		logic [31:0] rdata;
	} ivd_state_type;
endpackage
`default_nettype wire

// [verilog/ivd_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ivd_sync #(
	parameter int W = 9,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins in, synchronised levels out
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	// Two stages; the first is read only by the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= INIT;
			sync_o <= INIT;
		end else begin
			meta_q <= pin_i;
			sync_o <= meta_q;
		end
	end
endmodule // ivd_sync
`default_nettype wire

// [verilog/ivd_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none
module ivd_edge_det
	import ivd_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Synchronised level and edge choice
	input wire logic level_i,
	input wire logic rise_en_i,
	input wire logic fall_en_i,
	// One-cycle request pulse
	output logic hit_o
);
	ivd_edge_type s_q;
	ivd_edge_type s_d;
	// Both enables set gives a request on either edge
	always_comb begin
		s_d.prev = level_i;
		s_d.hit = (rise_en_i && level_i && !s_q.prev) || (fall_en_i && !level_i && s_q.prev);
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign hit_o = s_q.hit;
endmodule // ivd_edge_det
`default_nettype wire

// [verilog/ivd_dispatch.sv]
// Contract
// - Break, undefined-opcode and overflow-trap instructions raise their own fixed-vector interrupts.
// - Trap numbers 0..63; 0..31 share the peripheral vector slots.
// - Traps 0..31 and hardware interrupts save and clear stack select; return restores (the code ignores a return in a cycle that accepts a source).
// - Traps 32..63 leave the stack select flag unchanged.
// - Reset, pin NMI, debugger break, watchdog, step, match are never maskable.
// - Low reset pin holds reset; low NMI pin raises the NMI.
// - Debug step flag set raises a single-step interrupt after every instruction.
// - Match enable set raises match interrupt before the instruction at the match address.
// - A match address that is not an instruction start never raises.
// - Peripheral interrupts are maskable and use relocatable entries 0..31 (the code takes requests on slots 1..31 only).
// - Low key pin requests; edge pins 0..5 request on rise, fall or both.
// - Fixed four-byte vectors FFFDC..FFFFF in the documented order.
// - NMI at FFFF8, reset at FFFFC, watchdog at FFFF0.
// - Break whose fixed vector holds FF restarts from relocatable entry 0.
// - Relocatable table is 256 bytes from the base; entry n at 4n.
// - Entries 4..14 carry pin 3, timers, serial/pins, collision, DMA, key, A-D.
// - Entries 15..31 carry serial ports, timers A and B, pins 0..2.
// - Entries 8 and 9 sources chosen by cause select bits 6 and 7.
// - In two-wire mode serial 2 slots serve not-acknowledge and acknowledge.
// - Entry 0 break and traps 32..63 ignore the global mask flag.
// - Maskable requests gated by global mask, source level and processor level.
// - Request bit and level live per source; mask and level in flag word.
// - Accept only with mask flag 1, request 1, level above processor level.
// - Level field three bits; zero disables, 1 lowest to 7 highest.
// - Hardware sets request, clears it on acceptance; software may only clear.
// - Accept loads level; watchdog and NMI load 7, reset 0, others keep.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ivd_regs.svh"
module ivd_dispatch
	import ivd_pkg::*;
#(
	parameter int SLOTS = 32,
	parameter int AW = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire ivd_bus_req_type bus_i,
	output logic [31:0] rdata_o,
	// CPU sequencer events
	input wire ivd_cpu_ev_type cpu_ev_i,
	// Pins, active low where named so
	input wire logic reset_pin_n_i,
	input wire logic nmi_pin_n_i,
	input wire logic key_input_pin_n_i,
	input wire logic [5:0] ext_edge_pin_i,
	// Peripheral request pulses, one per relocatable slot
	input wire logic [31:0] periph_req_i,
	input wire logic nack_req_i,
	input wire logic ack_req_i,
	// Vector fetch port, byte data taken while the read strobe stands
	output logic mem_rd_o,
	output logic [19:0] mem_addr_o,
	input wire logic [7:0] mem_data_i,
	// Dispatch results
	output logic [19:0] handler_pc_o,
	output logic handler_valid_o,
	output logic [5:0] flag_word_o,
	output logic [5:0] saved_flags_o,
	output logic cpu_reset_o,
	output logic busy_o
);
	// Structure is sized for the documented table only
	if (SLOTS != 32 || AW != 20) begin : g_bad_size
		$error("ivd_dispatch serves 32 slots and 20-bit addresses only");
	end

	ivd_state_type s_q;
	ivd_state_type s_d;
	logic [8:0] pin_s;
	logic [5:0] edge_hit;
	logic [31:0] src;
	logic best_ok;
	logic [4:0] best_slot;
	logic [2:0] best_lvl;
	logic mask_ok;
	logic keep_u;
	ivd_kind_type kind;
	logic [19:0] vsel;
	logic bus_icr;

	// Pins cross into the clock domain first
	ivd_sync #(
		.W(9),
		.INIT(`IVD_PIN_RST_VAL)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({ext_edge_pin_i, key_input_pin_n_i, nmi_pin_n_i, reset_pin_n_i}),
		.sync_o(pin_s)
	);

	// One edge detector per external edge pin
	for (genvar k = 0; k < 6; k++) begin : g_edge
		ivd_edge_det u_edge (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.level_i(pin_s[`IVD_PIN_EXT + k]),
			.rise_en_i(s_q.edge_cfg[2 * k]),
			.fall_en_i(s_q.edge_cfg[2 * k + 1]),
			.hit_o(edge_hit[k])
		);
	end

	always_comb begin
		s_d = s_q;
		s_d.pc_valid = 1'b0;
		s_d.mem_rd = 1'b0;
		// Route every source onto its relocatable slot
		src = periph_req_i;
		src[0] = 1'b0;
		src[4] = edge_hit[3];
		src[8] = s_q.cause_sel[0] ? edge_hit[5] : periph_req_i[8];
		src[9] = s_q.cause_sel[1] ? edge_hit[4] : periph_req_i[9];
		src[13] = ~pin_s[`IVD_PIN_KEY];
		src[15] = s_q.twowire ? nack_req_i : periph_req_i[15];
		src[16] = s_q.twowire ? ack_req_i : periph_req_i[16];
		src[31:29] = edge_hit[2:0];
		// Highest level wins; ties go to the lowest slot
		best_ok = 1'b0;
		best_slot = 5'h00;
		best_lvl = 3'h0;
		for (int n = 1; n < SLOTS; n++) begin
			if (s_q.ctl[n].req && s_q.ctl[n].lvl > best_lvl) begin
				best_ok = 1'b1;
				best_slot = 5'(n);
				best_lvl = s_q.ctl[n].lvl;
			end
		end
		mask_ok = best_ok && s_q.flags.i && (best_lvl > s_q.flags.processor_priority_level);
		// Choose one source: pending reset when idle with its pin high, the rest at an instruction boundary
		kind = K_NONE;
		if (s_q.fsm == IVD_IDLE) begin
			if (s_q.rst_pend && pin_s[`IVD_PIN_RST]) begin
				kind = K_RST;
			end else if (!s_q.cpu_reset && cpu_ev_i.bound) begin
				// Executed instructions first, as they do not pend; one that arrives while not idle is dropped
				if (cpu_ev_i.undefined_opcode_instr) kind = K_UND;
				else if (cpu_ev_i.ovf) kind = K_OVF;
				else if (cpu_ev_i.break_instr) kind = K_BRK;
				else if (cpu_ev_i.trap) kind = K_TRAP;
				else if (s_q.nmi_pend) kind = K_NMI;
				else if (s_q.dbc_pend) kind = K_DBC;
				else if (s_q.wdt_pend) kind = K_WDT;
				else if (s_q.flags.d) kind = K_STEP;
				else if (s_q.match_en && cpu_ev_i.next_addr == s_q.match_addr) kind = K_MATCH;
				else if (mask_ok) kind = K_MASK;
			end
		end
		keep_u = (kind == K_TRAP) && (cpu_ev_i.trap_num >= `IVD_TRAP_SPLIT);
		// Vector address for the chosen source
		unique case (kind)
			K_RST: vsel = `IVD_VEC_RST;
			K_NMI: vsel = `IVD_VEC_NMI;
			K_DBC: vsel = `IVD_VEC_DBC;
			K_WDT: vsel = `IVD_VEC_WDT;
			K_UND: vsel = `IVD_VEC_UND;
			K_OVF: vsel = `IVD_VEC_OVF;
			K_BRK: vsel = `IVD_VEC_BRK;
			K_STEP: vsel = `IVD_VEC_STEP;
			K_MATCH: vsel = `IVD_VEC_MATCH;
			K_TRAP: vsel = s_q.base + {12'h000, cpu_ev_i.trap_num, 2'b00};
			K_MASK: vsel = s_q.base + {13'h0, best_slot, 2'b00};
			default: vsel = s_q.base;
		endcase
		// Reset pin holds the core while low, NMI pends on the fall
		s_d.cpu_reset = ~pin_s[`IVD_PIN_RST];
		if (!pin_s[`IVD_PIN_RST]) begin
			s_d.rst_pend = 1'b1;
		end
		s_d.nmi_prev = pin_s[`IVD_PIN_NMI];
		if (s_q.nmi_prev && !pin_s[`IVD_PIN_NMI]) begin
			s_d.nmi_pend = 1'b1;
		end

		// Register writes; request bits can only be cleared here
		bus_icr = (bus_i.addr & `IVD_ICR_MASK) == `IVD_OFS_ICR;
		if (bus_i.we) begin
			if (bus_icr) begin
				s_d.ctl[bus_i.addr[4:0]].lvl = bus_i.wdata[2:0];
				s_d.ctl[bus_i.addr[4:0]].req = s_q.ctl[bus_i.addr[4:0]].req
					& bus_i.wdata[`IVD_ICR_REQ_BIT];
			end
			unique case (bus_i.addr)
				`IVD_OFS_FLAGS: s_d.flags = ivd_flag_type'(bus_i.wdata[5:0]);
				`IVD_OFS_BASE: s_d.base = bus_i.wdata[19:0];
				`IVD_OFS_MATCH: s_d.match_addr = bus_i.wdata[19:0];
				`IVD_OFS_MATCH_EN: s_d.match_en = bus_i.wdata[0];
				`IVD_OFS_MODE: s_d.twowire = bus_i.wdata[`IVD_MODE_TWOWIRE_BIT];
				`IVD_OFS_EDGE: s_d.edge_cfg = bus_i.wdata[11:0];
				`IVD_OFS_CAUSE: s_d.cause_sel = {bus_i.wdata[`IVD_CAUSE_SEL9_BIT],
					bus_i.wdata[`IVD_CAUSE_SEL8_BIT]};
				default: ;
			endcase
		end

		// Register reads answer in the next cycle, unmapped reads zero
		s_d.rdata = 32'h00000000;
		if (bus_i.re) begin
			if (bus_icr) begin
				s_d.rdata = {28'h0000000, s_q.ctl[bus_i.addr[4:0]]};
			end
			unique case (bus_i.addr)
				`IVD_OFS_FLAGS: s_d.rdata = {26'h0, s_q.flags};
				`IVD_OFS_BASE: s_d.rdata = {12'h000, s_q.base};
				`IVD_OFS_MATCH: s_d.rdata = {12'h000, s_q.match_addr};
				`IVD_OFS_MATCH_EN: s_d.rdata = {31'h0, s_q.match_en};
				`IVD_OFS_MODE: s_d.rdata = {31'h0, s_q.twowire};
				`IVD_OFS_EDGE: s_d.rdata = {20'h00000, s_q.edge_cfg};
				`IVD_OFS_CAUSE: s_d.rdata = {24'h000000, s_q.cause_sel, 6'h00};
				default: ;
			endcase
		end

		// Pending special sources
		if (cpu_ev_i.dbc) s_d.dbc_pend = 1'b1;
		if (cpu_ev_i.wdt) s_d.wdt_pend = 1'b1;

		// A return with no acceptance in the same cycle restores the flags saved at acceptance
		if (cpu_ev_i.reti && kind == K_NONE) begin
			s_d.flags = s_q.saved;
		end

		// Acceptance: save flags, clear I and D, maybe U, load level
		if (kind != K_NONE) begin
			s_d.saved = s_q.flags;
			s_d.flags.i = 1'b0;
			s_d.flags.d = 1'b0;
			if (!keep_u) begin
				s_d.flags.u = 1'b0;
			end
			unique case (kind)
				K_RST: begin
					s_d.flags = `IVD_FLAGS_RST;
					s_d.flags.processor_priority_level = `IVD_IPL_RESET;
					s_d.rst_pend = 1'b0;
				end
				K_NMI: begin
					s_d.flags.processor_priority_level = `IVD_IPL_TOP;
					s_d.nmi_pend = 1'b0;
				end
				K_WDT: begin
					s_d.flags.processor_priority_level = `IVD_IPL_TOP;
					s_d.wdt_pend = 1'b0;
				end
				K_DBC: s_d.dbc_pend = 1'b0;
				K_MASK: begin
					s_d.flags.processor_priority_level = best_lvl;
					s_d.ctl[best_slot].req = 1'b0;
				end
				default: ;
			endcase
			s_d.vec = vsel;
			s_d.iss = 2'h0;
			s_d.got = 2'h0;
			s_d.brk_redo = (kind == K_BRK);
			s_d.fsm = IVD_FETCH;
		end

		// A new request beats a clear in the same cycle
		for (int n = 1; n < SLOTS; n++) begin
			if (src[n]) begin
				s_d.ctl[n].req = 1'b1;
			end
		end

		// Vector fetch, low byte first, reads pipelined back to back
		unique case (s_q.fsm)
			IVD_IDLE: ;
			IVD_FETCH: begin
				if (s_q.iss != `IVD_FETCH_BYTES) begin
					s_d.mem_rd = 1'b1;
					s_d.mem_addr = s_q.vec + {18'h0, s_q.iss};
					s_d.iss = s_q.iss + 2'h1;
				end
				if (s_q.mem_rd) begin
					unique case (s_q.got)
						2'h0: s_d.pc[7:0] = mem_data_i;
						2'h1: s_d.pc[15:8] = mem_data_i;
						default: s_d.pc[19:16] = mem_data_i[3:0];
					endcase
					s_d.got = s_q.got + 2'h1;
					if (s_q.got == 2'h2) begin
						if (s_q.brk_redo && s_q.pc[7:0] == `IVD_BRK_REDIRECT) begin
							s_d.vec = s_q.base;
							s_d.iss = 2'h0;
							s_d.got = 2'h0;
							s_d.brk_redo = 1'b0;
						end else begin
							s_d.fsm = IVD_DONE;
						end
					end
				end
			end
			IVD_DONE: begin
				s_d.pc_valid = 1'b1;
				s_d.fsm = IVD_IDLE;
			end
			default: s_d.fsm = IVD_IDLE;
		endcase

		// The reset pin aborts a dispatch still fetching; one already in IVD_DONE still pulses valid
		if (!pin_s[`IVD_PIN_RST]) begin
			s_d.fsm = IVD_IDLE;
			s_d.mem_rd = 1'b0;
		end
		s_d.busy = (s_d.fsm != IVD_IDLE);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.fsm <= IVD_IDLE;
			s_q.rst_pend <= 1'b1;
			s_q.nmi_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register
	assign rdata_o = s_q.rdata;
	assign mem_rd_o = s_q.mem_rd;
	assign mem_addr_o = s_q.mem_addr;
	assign handler_pc_o = s_q.pc;
	assign handler_valid_o = s_q.pc_valid;
	assign flag_word_o = s_q.flags;
	assign saved_flags_o = s_q.saved;
	assign cpu_reset_o = s_q.cpu_reset;
	assign busy_o = s_q.busy;

	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence seq_three_reads;
		mem_rd_o [*3] ##1 !mem_rd_o;
	endsequence

	a_fetch_three: assert property ((kind != K_NONE) |=> ##1 seq_three_reads)
		else $error("vector fetch is not three reads");
	a_fetch_base: assert property ((kind != K_NONE) |=> ##1 mem_addr_o == $past(vsel, 2))
		else $error("first vector read not at vector address");
	a_trap_u_keep: assert property ((kind == K_TRAP && keep_u) |=> flag_word_o[2] == $past(flag_word_o[2]))
		else $error("high trap changed stack select");
	a_hw_u_clear: assert property ((kind == K_MASK || kind == K_NMI) |=> !flag_word_o[2])
		else $error("stack select not cleared");
	a_mask_gate: assert property ((kind == K_MASK) |-> s_q.flags.i && best_lvl > s_q.flags.processor_priority_level)
		else $error("masked request accepted");
	a_lvl_zero: assert property ((kind == K_MASK) |-> s_q.ctl[best_slot].lvl != 3'h0)
		else $error("level zero source accepted");
	a_nmi_level: assert property ((kind == K_NMI || kind == K_WDT) |=> flag_word_o[5:3] == 3'h7)
		else $error("nmi or watchdog did not load top level");
	a_req_clear: assert property ((kind == K_MASK && !src[best_slot]) |=> !s_q.ctl[$past(best_slot)].req)
		else $error("request bit not cleared on acceptance");
	a_reset_hold: assert property (!pin_s[`IVD_PIN_RST] |=> cpu_reset_o && !busy_o)
		else $error("reset pin low but core not held");
	a_step_raise: assert property ((s_q.fsm == IVD_IDLE && !s_q.cpu_reset && cpu_ev_i.bound && s_q.flags.d
		&& !s_q.rst_pend) |-> kind != K_NONE)
		else $error("single step not raised");
	a_brk_redir: assert property ((s_q.fsm == IVD_FETCH && s_q.mem_rd && s_q.got == 2'h2 && s_q.brk_redo
		&& s_q.pc[7:0] == 8'hFF) |=> ##1 (mem_rd_o && mem_addr_o == s_q.base))
		else $error("break redirect not taken");
endmodule // ivd_dispatch
`default_nettype wire

// [verification/ivd_vec_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module ivd_vec_mem (
	// Clock
	input wire logic clk_i,
	// Byte fetch port
	input wire logic mem_rd_i,
	input wire logic [19:0] mem_addr_i,
	output logic [7:0] mem_data_o,
	// Plants the break redirect marker
	input wire logic brk_ff_i
);
	// Byte answers while the read stands, as the fetch logic takes it there
	// An idle port shows the inverse, so a byte taken outside a read is caught
	always_comb begin
		mem_data_o = mem_addr_i[7:0] ^ 8'h3C;
		if (brk_ff_i && mem_addr_i == 20'hFFFE4) begin
			mem_data_o = 8'hFF;
		end
		if (!mem_rd_i) begin
			mem_data_o = ~mem_data_o;
		end
	end
endmodule // ivd_vec_mem
`default_nettype wire

// [verification/interrupt_vector_dispatch_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ivd_regs.svh"
module interrupt_vector_dispatch_test
	import ivd_pkg::*;
;
	// Bench signals
	logic clk_i, rst_i, reset_pin_n_i, nmi_pin_n_i, brk_ff;
	logic key_input_pin_n_i, nack_req_i, ack_req_i;
	logic [5:0] ext_edge_pin_i;
	ivd_bus_req_type bus_i;
	ivd_cpu_ev_type cpu_ev_i;
	logic [31:0] periph_req_i, rdata_o;
	logic [7:0] mem_data_i;
	logic [19:0] mem_addr_o, handler_pc_o;
	logic mem_rd_o, handler_valid_o, cpu_reset_o, busy_o;
	logic [5:0] flag_word_o, saved_flags_o;
	int failures, checks_done;
	localparam logic [19:0] BASE = 20'h12340;

	ivd_dispatch i_ivd_dispatch (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.cpu_ev_i(cpu_ev_i), .reset_pin_n_i(reset_pin_n_i), .nmi_pin_n_i(nmi_pin_n_i),
		.key_input_pin_n_i(key_input_pin_n_i), .ext_edge_pin_i(ext_edge_pin_i),
		.periph_req_i(periph_req_i), .nack_req_i(nack_req_i), .ack_req_i(ack_req_i),
		.mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
		.mem_data_i(mem_data_i), .handler_pc_o(handler_pc_o), .handler_valid_o(handler_valid_o),
		.flag_word_o(flag_word_o), .saved_flags_o(saved_flags_o), .cpu_reset_o(cpu_reset_o),
		.busy_o(busy_o));
	ivd_vec_mem i_ivd_vec_mem (.clk_i(clk_i), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
		.mem_data_o(mem_data_i), .brk_ff_i(brk_ff));

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", w, e, s);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Handler address the vector memory model yields for a vector at v
	function automatic logic [19:0] pcof(input logic [19:0] v);
		logic [19:0] a1, a2;
		a1 = v + 20'h1;
		a2 = v + 20'h2;
		return {a2[3:0] ^ 4'hC, a1[7:0] ^ 8'h3C, v[7:0] ^ 8'h3C};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus_i <= {2'b10, a, d};
		@(posedge clk_i);
		bus_i <= '0;
	endtask

	task automatic rd(input string w, input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_i);
		bus_i <= {2'b01, a, 32'h0};
		@(posedge clk_i);
		bus_i <= '0;
		#1 chk(w, rdata_o, e);
	endtask

	// k = {bound, brk, und, ovf, trap, reti, dbc, wdt}
	task automatic ev(input logic [7:0] k, input logic [5:0] n, input logic [19:0] na);
		@(posedge clk_i);
		cpu_ev_i <= {k[7], na, k[6:3], n, k[2:0]};
		@(posedge clk_i);
		cpu_ev_i <= '0;
	endtask

	// Bounded wait for the handler address, then compare it and the level
	task automatic take(input string w, input logic [19:0] v, input logic [2:0] processor_priority_level);
		logic seen;
		seen = 1'b0;
		repeat (40) begin
			@(posedge clk_i);
			#1;
			if (handler_valid_o === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
		chk({w, " valid"}, seen, 1'b1);
		chk({w, " pc"}, handler_pc_o, pcof(v));
		chk({w, " ipl"}, flag_word_o[5:3], processor_priority_level);
	endtask

	// No dispatch may start
	task automatic quiet(input string w);
		logic act;
		act = 1'b0;
		repeat (8) begin
			@(posedge clk_i);
			#1 act = act | busy_o | handler_valid_o;
		end
		chk(w, act, 1'b0);
	endtask

	task automatic t_regs();
		wr(`IVD_OFS_BASE, {12'h000, BASE});
		rd("base", `IVD_OFS_BASE, {12'h000, BASE});
		rd("unmapped", 12'h7FF, 32'h0);
		wr(`IVD_OFS_ICR + 12'h00E, 32'hF);
		rd("icr sw set", `IVD_OFS_ICR + 12'h00E, 32'h7);
	endtask

	task automatic t_soft();
		wr(`IVD_OFS_FLAGS, 32'h28);
		ev(8'hA0, 6'h00, 20'h0);
		take("und", `IVD_VEC_UND, 3'h5);
		ev(8'h90, 6'h00, 20'h0);
		take("ovf", `IVD_VEC_OVF, 3'h5);
		ev(8'hC0, 6'h00, 20'h0);
		take("brk", `IVD_VEC_BRK, 3'h5);
		brk_ff <= 1'b1;
		ev(8'hC0, 6'h00, 20'h0);
		take("brk redirect", BASE, 3'h5);
		brk_ff <= 1'b0;
	endtask

	task automatic t_trap();
		wr(`IVD_OFS_FLAGS, 32'h04);
		ev(8'h88, 6'h05, 20'h0);
		take("trap5", BASE + 20'h14, 3'h0);
		chk("trap5 u", flag_word_o[2], 1'b0);
		chk("trap5 saved u", saved_flags_o[2], 1'b1);
		ev(8'h84, 6'h00, 20'h0);
		@(posedge clk_i);
		#1 chk("reti u", flag_word_o[2], 1'b1);
		ev(8'h88, 6'h3F, 20'h0);
		take("trap63", BASE + 20'hFC, 3'h0);
		chk("trap63 u", flag_word_o[2], 1'b1);
	endtask

	task automatic t_mask();
		wr(`IVD_OFS_ICR + 12'h015, 32'h3);
		wr(`IVD_OFS_FLAGS, 32'h10);
		@(posedge clk_i);
		periph_req_i <= 32'h0020_0000;
		@(posedge clk_i);
		periph_req_i <= '0;
		rd("icr req set", `IVD_OFS_ICR + 12'h015, 32'hB);
		ev(8'h80, 6'h00, 20'h0);
		quiet("mask flag clear");
		wr(`IVD_OFS_FLAGS, 32'h19);
		ev(8'h80, 6'h00, 20'h0);
		quiet("level not above");
		wr(`IVD_OFS_FLAGS, 32'h11);
		ev(8'h80, 6'h00, 20'h0);
		take("timer slot", BASE + 20'h54, 3'h3);
		rd("icr req clear", `IVD_OFS_ICR + 12'h015, 32'h3);
	endtask

	task automatic t_special();
		wr(`IVD_OFS_FLAGS, 32'h00);
		nmi_pin_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		ev(8'h80, 6'h00, 20'h0);
		take("nmi", `IVD_VEC_NMI, 3'h7);
		@(posedge clk_i) nmi_pin_n_i <= 1'b1;
		ev(8'h01, 6'h00, 20'h0);
		ev(8'h80, 6'h00, 20'h0);
		take("wdt", `IVD_VEC_WDT, 3'h7);
		ev(8'h02, 6'h00, 20'h0);
		ev(8'h80, 6'h00, 20'h0);
		take("dbc", `IVD_VEC_DBC, 3'h7);
		wr(`IVD_OFS_FLAGS, 32'h02);
		ev(8'h80, 6'h00, 20'h0);
		take("step", `IVD_VEC_STEP, 3'h0);
		wr(`IVD_OFS_MATCH, 32'h01230);
		wr(`IVD_OFS_MATCH_EN, 32'h1);
		ev(8'h80, 6'h00, 20'h01231);
		quiet("match miss");
		ev(8'h80, 6'h00, 20'h01230);
		take("match", `IVD_VEC_MATCH, 3'h0);
		wr(`IVD_OFS_MATCH_EN, 32'h0);
	endtask

	// Pins, cause select and two-wire mode steer their slots
	task automatic t_pins();
		ext_edge_pin_i <= 6'h20;
		wr(`IVD_OFS_EDGE, 32'h840);
		wr(`IVD_OFS_CAUSE, 32'h40);
		wr(`IVD_OFS_MODE, 32'h1);
		@(posedge clk_i);
		key_input_pin_n_i <= 1'b0;
		ext_edge_pin_i <= 6'h08;
		nack_req_i <= 1'b1;
		periph_req_i <= 32'h0001_0000;
		@(posedge clk_i);
		key_input_pin_n_i <= 1'b1;
		nack_req_i <= 1'b0;
		periph_req_i <= '0;
		repeat (4) @(posedge clk_i);
		rd("pin3 rise", `IVD_OFS_ICR + 12'h004, 32'h8);
		rd("pin5 fall", `IVD_OFS_ICR + 12'h008, 32'h8);
		rd("key low", `IVD_OFS_ICR + 12'h00D, 32'h8);
		rd("nack slot", `IVD_OFS_ICR + 12'h00F, 32'h8);
		rd("ack slot idle", `IVD_OFS_ICR + 12'h010, 32'h0);
		@(posedge clk_i);
		ack_req_i <= 1'b1;
		@(posedge clk_i);
		ack_req_i <= 1'b0;
		rd("ack slot", `IVD_OFS_ICR + 12'h010, 32'h8);
	endtask

	task automatic t_pin_reset();
		wr(`IVD_OFS_FLAGS, 32'h3D);
		@(posedge clk_i);
		reset_pin_n_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1 chk("cpu reset", cpu_reset_o, 1'b1);
		@(posedge clk_i);
		reset_pin_n_i <= 1'b1;
		take("pin reset", `IVD_VEC_RST, 3'h0);
		chk("reset flags", flag_word_o, 6'h00);
	endtask

	// Whole run is a few hundred cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		complete_run();
	end

	initial begin
		failures = 0;
		checks_done = 0;
		rst_i = 1'b1;
		reset_pin_n_i = 1'b1;
		nmi_pin_n_i = 1'b1;
		brk_ff = 1'b0;
		bus_i = '0;
		cpu_ev_i = '0;
		periph_req_i = '0;
		key_input_pin_n_i = 1'b1;
		ext_edge_pin_i = 6'h00;
		nack_req_i = 1'b0;
		ack_req_i = 1'b0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		take("reset", `IVD_VEC_RST, 3'h0);
		chk("cpu reset idle", cpu_reset_o, 1'b0);
		t_regs();
		t_soft();
		t_trap();
		t_mask();
		t_special();
		t_pins();
		t_pin_reset();
		complete_run();
	end
endmodule // interrupt_vector_dispatch_test
`default_nettype wire
